//--- verilog/gpr_gpio.sv
// Pin control and data registers with APB slave and wake interrupt
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps

module gpr_gpio #(
    parameter int PADDR_W = 12
) (
    // Clock, reset, enable
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Pins: 0 is 1.7, 1..5 are 2.0..2.4
    input  wire logic [5:0]         pin_in,
    output logic [5:0]              pin_out,
    output logic [5:0]              pin_oe,
    input  wire logic [6:0]         group1_low_in,
    // Alternate functions
    output logic                    fan_speed_input_2,
    input  wire logic [3:0]         display_chan_pull_low,
    output logic [3:0]              display_chan_level,
    input  wire logic               down_control_enable_n,
    output logic                    wake_event,
    // Interrupt
    output logic                    irq
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (PADDR_W < 9 || PADDR_W > 12)
    begin : g_bad_width
        $error("PADDR_W must lie between 9 and 12");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [5:0][7:0] ctrl;
        logic [5:0]      data;
        logic [6:0]      data1_low;
        logic            ldn_sel;
        logic [5:0]      pin_s1;
        logic [5:0]      pin_s2;
        logic [5:0]      pin_prev;
        logic [6:0]      g1_s1;
        logic [6:0]      g1_s2;
        logic [1:0]      status;
        logic [1:0]      enable;
        logic            pready;
        logic [31:0]     prdata;
        logic [5:0]      pin_out;
        logic [5:0]      pin_oe;
        logic            fan;
        logic            wake;
        logic            irq;
    } gpr_state_t;

    gpr_state_t s;
    gpr_state_t next_s;

    logic [9:0] idx;
    logic [9:0] local_idx;
    logic       in_block;
    logic       own_reg;
    logic [7:0] rd_val;
    logic       wr_done;
    logic [5:0] is_ddc;
    logic [5:0] is_either_edge_wake_input;
    logic       is_tach;
    logic       is_down;
    logic [5:0] pin_rd;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [5:0] pull_pin;

    assign idx = 10'(paddr[PADDR_W-1:2]);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s    = s;
        local_idx = 10'h000;
        in_block  = 1'b0;
        own_reg   = 1'b0;
        rd_val    = 8'h00;
        ev        = 2'h0;
        clr       = 2'h0;
        pull_pin  = {1'b0, display_chan_pull_low, 1'b0};
        wr_done   = psel && penable && s.pready && pwrite;

        // Address decode, block moved up when selected
        if (idx >= gpr_pkg::IDX_LDN_SELECT)
        begin
            own_reg = 1'b1;
        end
        else if (s.ldn_sel && idx >= gpr_pkg::IDX_COMBINED_BASE)
        begin
            in_block  = 1'b1;
            local_idx = idx - gpr_pkg::IDX_COMBINED_BASE;
        end
        else if (!s.ldn_sel && idx < gpr_pkg::IDX_BLOCK_SIZE)
        begin
            in_block  = 1'b1;
            local_idx = idx;
        end

        // Function selection per pin
        is_tach = s.ctrl[0][gpr_pkg::BIT_ALT];
        is_ddc  = 6'h00;
        is_either_edge_wake_input = 6'h00;
        is_ddc[1]  = s.ctrl[1][gpr_pkg::BIT_ALT];
        is_ddc[2]  = s.ctrl[2][gpr_pkg::BIT_ALTH:gpr_pkg::BIT_ALT] == gpr_pkg::ALT2_DDC;
        is_either_edge_wake_input[2] = s.ctrl[2][gpr_pkg::BIT_ALTH:gpr_pkg::BIT_ALT] == gpr_pkg::ALT2_EITHER_EDGE_WAKE_INPUT;
        is_ddc[3]  = s.ctrl[3][gpr_pkg::BIT_ALTH:gpr_pkg::BIT_ALT] == gpr_pkg::ALT2_DDC;
        is_either_edge_wake_input[3] = s.ctrl[3][gpr_pkg::BIT_ALTH:gpr_pkg::BIT_ALT] == gpr_pkg::ALT2_EITHER_EDGE_WAKE_INPUT;
        is_ddc[4]  = s.ctrl[4][gpr_pkg::BIT_ALT];
        is_down    = s.ctrl[5][gpr_pkg::BIT_ALT];

        // Data view of each pin
        for (int i = 0; i < 6; i++)
        begin
            if (is_ddc[i])
            begin
                pin_rd[i] = s.pin_s2[i];
            end
            else if (s.ctrl[i][gpr_pkg::BIT_DIR])
            begin
                pin_rd[i] = s.pin_s2[i] ^ s.ctrl[i][gpr_pkg::BIT_POL];
            end
            else
            begin
                pin_rd[i] = s.data[i];
            end
        end

        // Read mux
        if (in_block)
        begin
            if (local_idx >= gpr_pkg::IDX_PIN_B1_7 && local_idx <= gpr_pkg::IDX_PIN_B2_4)
            begin
                rd_val = s.ctrl[3'(local_idx - gpr_pkg::IDX_PIN_B1_7)];
            end
            else if (local_idx == gpr_pkg::IDX_GROUP1_DATA)
            begin
                rd_val = {pin_rd[0], s.data1_low};
            end
            else if (local_idx == gpr_pkg::IDX_GROUP2_DATA)
            begin
                rd_val = {3'h0, pin_rd[5:1]};
            end
            else
            begin
                rd_val = 8'h00;
            end
        end
        else if (own_reg)
        begin
            if (idx == gpr_pkg::IDX_LDN_SELECT)
            begin
                rd_val = {7'h00, s.ldn_sel};
            end
            else if (idx == gpr_pkg::IDX_IRQ_STATUS)
            begin
                rd_val = {6'h00, s.status};
            end
            else if (idx == gpr_pkg::IDX_IRQ_ENABLE)
            begin
                rd_val = {6'h00, s.enable};
            end
        end

        if (ce)
        begin
            // Synchronisers
            next_s.pin_s1    = pin_in;
            next_s.pin_s2    = s.pin_s1;
            next_s.g1_s1     = group1_low_in;
            next_s.g1_s2     = s.g1_s1;
            next_s.data1_low = s.g1_s2;
            next_s.pin_prev  = s.pin_s2;

            // APB handshake: answer in second access cycle
            next_s.pready = psel && penable && !s.pready;
            if (psel && penable && !s.pready)
            begin
                next_s.prdata = {24'h000000, rd_val};
            end

            // Register writes
            if (wr_done && in_block)
            begin
                if (local_idx == gpr_pkg::IDX_PIN_B2_1 || local_idx == gpr_pkg::IDX_PIN_B2_2)
                begin
                    next_s.ctrl[3'(local_idx - gpr_pkg::IDX_PIN_B1_7)] =
                        pwdata[7:0] & gpr_pkg::MASK_CTRL_2BIT;
                end
                else if (local_idx >= gpr_pkg::IDX_PIN_B1_7 && local_idx <= gpr_pkg::IDX_PIN_B2_4)
                begin
                    next_s.ctrl[3'(local_idx - gpr_pkg::IDX_PIN_B1_7)] =
                        pwdata[7:0] & gpr_pkg::MASK_CTRL_1BIT;
                end
                else if (local_idx == gpr_pkg::IDX_GROUP1_DATA)
                begin
                    next_s.data[0] = pwdata[7];
                end
                else if (local_idx == gpr_pkg::IDX_GROUP2_DATA)
                begin
                    next_s.data[5:1] = pwdata[4:0] & gpr_pkg::MASK_GROUP2[4:0];
                end
            end
            if (wr_done && own_reg)
            begin
                if (idx == gpr_pkg::IDX_LDN_SELECT)
                begin
                    next_s.ldn_sel = pwdata[0];
                end
                else if (idx == gpr_pkg::IDX_IRQ_CLEAR)
                begin
                    clr = pwdata[1:0];
                end
                else if (idx == gpr_pkg::IDX_IRQ_ENABLE)
                begin
                    next_s.enable = pwdata[1:0];
                end
            end

            // Either edge wake input on pins 2.1 and 2.2
            if (|(is_either_edge_wake_input & (s.pin_s2 ^ s.pin_prev)))
            begin
                ev[gpr_pkg::STS_WAKE] = 1'b1;
                ev[gpr_pkg::STS_MISC] = 1'b1;
            end
            next_s.status = (s.status & ~clr) | ev;
            next_s.wake   = ev[gpr_pkg::STS_WAKE];
            next_s.irq    = |(s.status & s.enable);

            // Pin drivers
            for (int i = 0; i < 6; i++)
            begin
                next_s.pin_out[i] = 1'b0;
                next_s.pin_oe[i]  = 1'b0;
                if (is_ddc[i])
                begin
                    next_s.pin_oe[i] = pull_pin[i];
                end
                else if (is_either_edge_wake_input[i] || (i == 0 && is_tach))
                begin
                    next_s.pin_oe[i] = 1'b0;
                end
                else if (i == 5 && is_down)
                begin
                    if (s.ctrl[i][gpr_pkg::BIT_OD])
                    begin
                        next_s.pin_oe[i] = !down_control_enable_n;
                    end
                    else
                    begin
                        next_s.pin_out[i] = down_control_enable_n;
                        next_s.pin_oe[i]  = 1'b1;
                    end
                end
                else if (!s.ctrl[i][gpr_pkg::BIT_DIR])
                begin
                    if (s.ctrl[i][gpr_pkg::BIT_OD])
                    begin
                        next_s.pin_oe[i] = !(s.data[i] ^ s.ctrl[i][gpr_pkg::BIT_POL]);
                    end
                    else
                    begin
                        next_s.pin_out[i] = s.data[i] ^ s.ctrl[i][gpr_pkg::BIT_POL];
                        next_s.pin_oe[i]  = 1'b1;
                    end
                end
            end
            next_s.fan = is_tach && s.pin_s2[0];
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s         <= '0;
            s.ctrl[0] <= gpr_pkg::RST_PIN_B1_7;
            s.ctrl[1] <= gpr_pkg::RST_PIN_B2_X;
            s.ctrl[2] <= gpr_pkg::RST_PIN_B2_X;
            s.ctrl[3] <= gpr_pkg::RST_PIN_B2_X;
            s.ctrl[4] <= gpr_pkg::RST_PIN_B2_X;
            s.ctrl[5] <= gpr_pkg::RST_PIN_B2_4;
            s.data    <= gpr_pkg::RST_DATA[5:0];
        end
        else
        begin
            s <= next_s;
        end
    end

    assign pready             = s.pready;
    assign prdata             = s.prdata;
    assign pslverr            = 1'b0;
    assign pin_out            = s.pin_out;
    assign pin_oe             = s.pin_oe;
    assign fan_speed_input_2  = s.fan;
    assign display_chan_level = s.pin_s2[4:1];
    assign wake_event         = s.wake;
    assign irq                = s.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence wake_edge_s;
        ce && is_either_edge_wake_input[2] && (s.pin_s2[2] != s.pin_prev[2]);
    endsequence

    sequence ctrl_write_s;
        ce && wr_done && in_block && local_idx == gpr_pkg::IDX_PIN_B2_1;
    endsequence

    output_drive_a: assert property (ce && !s.ctrl[1][0] && !s.ctrl[1][7] && !is_ddc[1]
        |=> pin_oe[1] && pin_out[1] == $past(s.data[1] ^ s.ctrl[1][1]))
        else $error("push-pull output level wrong");
    input_float_a: assert property (ce && s.ctrl[0][0] |=> !pin_oe[0])
        else $error("input pin is driven");
    open_drain_a: assert property (ce && !s.ctrl[2][0] && s.ctrl[2][7] && !is_ddc[2] && !is_either_edge_wake_input[2]
        |=> pin_out[2] == 1'b0)
        else $error("open drain drives high");
    edge_status_a: assert property (wake_edge_s |=> s.status == 2'h3 ##0 wake_event)
        else $error("edge did not set status");
    ctrl_mask_a: assert property (ctrl_write_s |=> s.ctrl[2][6:4] == 3'h0)
        else $error("reserved control bits stored");
    reserved_zero_a: assert property (psel && penable && !pready && !pwrite && in_block
        && local_idx >= 10'h00d && local_idx <= 10'h014 ##1 pready |-> prdata == 32'h0)
        else $error("reserved offset read nonzero");
    apb_wait_a: assert property (ce && psel && penable && !pready ##1 ce |-> pready ##1 !pready)
        else $error("apb answer timing wrong");
    irq_follow_a: assert property (ce |=> irq == |$past(s.status & s.enable))
        else $error("interrupt level wrong");
    ddc_ignore_a: assert property (ce && is_ddc[4] |=> pin_oe[4] == $past(display_chan_pull_low[3])
        && !pin_out[4])
        else $error("display line drive wrong");

endmodule : gpr_gpio

//--- inc/gpr_pkg.sv
// Shared constants for the pin control and data register block
package gpr_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_PIN_B1_7      = 10'h007;
    localparam logic [9:0] IDX_PIN_B2_0      = 10'h008;
    localparam logic [9:0] IDX_PIN_B2_1      = 10'h009;
    localparam logic [9:0] IDX_PIN_B2_2      = 10'h00a;
    localparam logic [9:0] IDX_PIN_B2_3      = 10'h00b;
    localparam logic [9:0] IDX_PIN_B2_4      = 10'h00c;
    localparam logic [9:0] IDX_GROUP1_DATA   = 10'h015;
    localparam logic [9:0] IDX_GROUP2_DATA   = 10'h016;
    localparam logic [9:0] IDX_BLOCK_SIZE    = 10'h020;
    localparam logic [9:0] IDX_COMBINED_BASE = 10'h020;
    localparam logic [9:0] IDX_LDN_SELECT    = 10'h040;
    localparam logic [9:0] IDX_IRQ_STATUS    = 10'h041;
    localparam logic [9:0] IDX_IRQ_CLEAR     = 10'h042;
    localparam logic [9:0] IDX_IRQ_ENABLE    = 10'h043;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int BIT_DIR  = 0;
    localparam int BIT_POL  = 1;
    localparam int BIT_ALT  = 2;
    localparam int BIT_ALTH = 3;
    localparam int BIT_OD   = 7;

    localparam logic [7:0] MASK_CTRL_1BIT = 8'h87;
    localparam logic [7:0] MASK_CTRL_2BIT = 8'h8f;
    localparam logic [7:0] MASK_GROUP2    = 8'h1f;

    localparam logic [1:0] ALT2_GPIO = 2'h0;
    localparam logic [1:0] ALT2_DDC  = 2'h1;
    localparam logic [1:0] ALT2_EITHER_EDGE_WAKE_INPUT = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PIN_B1_7 = 8'h01;
    localparam logic [7:0] RST_PIN_B2_X = 8'h04;
    localparam logic [7:0] RST_PIN_B2_4 = 8'h05;
    localparam logic [7:0] RST_DATA     = 8'h00;

    // ----------------------------------------------------------------
    // Status bit positions
    // ----------------------------------------------------------------
    localparam int STS_WAKE = 0;
    localparam int STS_MISC = 1;

endpackage : gpr_pkg

//--- dv/gpr_pins.sv
// Board-side pin model with pull-ups and external drivers
`timescale 1ns/10ps
module gpr_pins (
    // Design drive
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    // Board drive
    input  wire logic [5:0] board_en,
    input  wire logic [5:0] board_val,
    // Resolved levels
    output logic      [5:0] pin_in
);
    // Released lines take the board drive when board_en is set, else float up to the board pull-up
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (board_en[i] ? board_val[i] : 1'b1);
        end
    end
endmodule : gpr_pins

//--- dv/tb_gpr_gpio.sv
// Self-checking bench for the pin control and data register block
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin checks_done++; if ((ac) !== (ex)) begin errors++; \
    $display("FAIL %s exp %h got %h", nm, ex, ac); end end
module tb_gpr_gpio;
    logic        clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, fan, down_n = 1, wake_event, irq;
    logic [5:0]  pin_in, pin_out, pin_oe, board_en = 6'h3f, board_val = 6'h00;
    logic [6:0]  group1_low_in = 7'h00;
    logic [3:0]  pull_low = 4'h0, chan_level;
    logic [7:0]  v;
    int          errors = 0, checks_done = 0;

    always #4 clock = ~clock;

    gpr_gpio #(.PADDR_W(12)) i_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .group1_low_in(group1_low_in),
        .fan_speed_input_2(fan), .display_chan_pull_low(pull_low), .display_chan_level(chan_level),
        .down_control_enable_n(down_n), .wake_event(wake_event), .irq(irq));
    gpr_pins i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board_en(board_en), .board_val(board_val),
        .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Bus and helper tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata[7:0];
        `CHK("pslverr", 1'b0, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] x;
        apb(1'b1, idx, d, x);
    endtask : wr
    task automatic rd(input logic [9:0] idx, output logic [7:0] d);
        apb(1'b0, idx, 8'h00, d);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic wait_wake;
        int n;
        n = 0;
        while (wake_event !== 1'b1 && n < 10)
        begin
            @(posedge clock);
            n++;
        end
        `CHK("wake_event", 1'b1, wake_event)
    endtask : wait_wake

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] e;
        for (int i = 0; i < 6; i++)
        begin
            e = (i == 0) ? gpr_pkg::RST_PIN_B1_7 : gpr_pkg::RST_PIN_B2_X;
            if (i == 5) e = gpr_pkg::RST_PIN_B2_4;
            rd(gpr_pkg::IDX_PIN_B1_7 + 10'(i), v);
            `CHK("ctrl reset", e, v)
        end
        rd(gpr_pkg::IDX_GROUP1_DATA, v);
        `CHK("data1 reset", 8'h00, v)
        $display("test reset done");
    endtask : t_reset
    task automatic t_reserved;
        for (int i = 8'h0d; i <= 8'h1f; i++)
        begin
            if (i == 8'h15 || i == 8'h16) continue;
            wr(10'(i), 8'hff);
            rd(10'(i), v);
            `CHK("reserved", 8'h00, v)
        end
        wr(gpr_pkg::IDX_PIN_B1_7, 8'hff);
        rd(gpr_pkg::IDX_PIN_B1_7, v);
        `CHK("ctrl mask 1bit", 8'h87, v)
        wr(gpr_pkg::IDX_PIN_B2_1, 8'hff);
        rd(gpr_pkg::IDX_PIN_B2_1, v);
        `CHK("ctrl mask 2bit", 8'h8f, v)
        $display("test reserved done");
    endtask : t_reserved
    task automatic t_output;
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h00);
        wr(gpr_pkg::IDX_GROUP1_DATA, 8'h80);
        wt(4);
        `CHK("pp oe", 1'b1, pin_oe[0])
        `CHK("pp out", 1'b1, pin_out[0])
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h02);
        wt(4);
        `CHK("pp inverted", 1'b0, pin_out[0])
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h80);
        wt(4);
        `CHK("od released", 1'b0, pin_oe[0])
        wr(gpr_pkg::IDX_GROUP1_DATA, 8'h00);
        wt(4);
        `CHK("od pull oe", 1'b1, pin_oe[0])
        `CHK("od pull out", 1'b0, pin_out[0])
        $display("test output done");
    endtask : t_output
    task automatic t_input_tach;
        board_val[0] <= 1'b1;
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h01);
        wt(4);
        `CHK("in oe", 1'b0, pin_oe[0])
        rd(gpr_pkg::IDX_GROUP1_DATA, v);
        `CHK("in level", 1'b1, v[7])
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h03);
        rd(gpr_pkg::IDX_GROUP1_DATA, v);
        `CHK("in inverted", 1'b0, v[7])
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h05);
        wt(4);
        `CHK("tach high", 1'b1, fan)
        board_val[0] <= 1'b0;
        wt(4);
        `CHK("tach low", 1'b0, fan)
        board_val[0] <= 1'b1;
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h01);
        wt(4);
        `CHK("tach off", 1'b0, fan)
        $display("test input done");
    endtask : t_input_tach
    task automatic t_hold;
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h05);
        wt(4);
        ce <= 1'b0;
        board_val[0] <= 1'b0;
        wt(4);
        `CHK("frozen fan", 1'b1, fan)
        ce <= 1'b1;
        wt(4);
        `CHK("fan resumed", 1'b0, fan)
        board_val[0] <= 1'b1;
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h01);
        wt(4);
        $display("test hold done");
    endtask : t_hold
    task automatic t_data;
        for (int i = 0; i < 5; i++) wr(gpr_pkg::IDX_PIN_B2_0 + 10'(i), 8'h01);
        group1_low_in <= 7'h55;
        board_val <= 6'b101101;
        wt(4);
        rd(gpr_pkg::IDX_GROUP1_DATA, v);
        `CHK("data1 map", 8'hd5, v)
        rd(gpr_pkg::IDX_GROUP2_DATA, v);
        `CHK("data2 map", 8'h16, v)
        $display("test data done");
    endtask : t_data
    task automatic t_display;
        for (int i = 0; i < 4; i++) wr(gpr_pkg::IDX_PIN_B2_0 + 10'(i), 8'h86);
        board_val[4:1] <= 4'b1010;
        wt(4);
        `CHK("ddc level", 4'b1010, chan_level)
        `CHK("ddc ignore dir", 4'b0000, pin_oe[4:1])
        pull_low <= 4'b0011;
        wt(4);
        `CHK("ddc pull oe", 4'b0011, pin_oe[4:1])
        `CHK("ddc pull out", 4'b0000, pin_out[4:1])
        `CHK("ddc level pulled", 4'b1000, chan_level)
        pull_low <= 4'b0000;
        wr(gpr_pkg::IDX_PIN_B2_1, 8'h0c);
        wt(4);
        `CHK("field 11 gpio", 1'b1, pin_oe[2])
        $display("test display done");
    endtask : t_display
    task automatic t_down;
        wr(gpr_pkg::IDX_PIN_B2_4, 8'h04);
        down_n <= 1'b0;
        wt(4);
        `CHK("down pp oe", 1'b1, pin_oe[5])
        `CHK("down pp low", 1'b0, pin_out[5])
        wr(gpr_pkg::IDX_PIN_B2_4, 8'h87);
        wt(4);
        `CHK("down od pull", 1'b1, pin_oe[5])
        down_n <= 1'b1;
        wt(4);
        `CHK("down od release", 1'b0, pin_oe[5])
        $display("test down done");
    endtask : t_down
    task automatic t_wake;
        wr(gpr_pkg::IDX_IRQ_ENABLE, 8'h03);
        wr(gpr_pkg::IDX_PIN_B2_1, 8'h08);
        board_val[2] <= 1'b0;
        wt(4);
        wr(gpr_pkg::IDX_IRQ_CLEAR, 8'h03);
        board_val[2] <= 1'b1;
        wait_wake();
        wt(3);
        `CHK("irq rise", 1'b1, irq)
        rd(gpr_pkg::IDX_IRQ_STATUS, v);
        `CHK("status rise", 8'h03, v)
        wr(gpr_pkg::IDX_IRQ_CLEAR, 8'h03);
        wt(3);
        `CHK("irq cleared", 1'b0, irq)
        board_val[2] <= 1'b0;
        wait_wake();
        rd(gpr_pkg::IDX_IRQ_STATUS, v);
        `CHK("status fall", 8'h03, v)
        wr(gpr_pkg::IDX_IRQ_ENABLE, 8'h00);
        wt(3);
        `CHK("irq masked", 1'b0, irq)
        wr(gpr_pkg::IDX_IRQ_CLEAR, 8'h03);
        wr(gpr_pkg::IDX_PIN_B2_2, 8'h08);
        board_val[3] <= ~board_val[3];
        wait_wake();
        rd(gpr_pkg::IDX_IRQ_STATUS, v);
        `CHK("status pin 2.2", 8'h03, v)
        wr(gpr_pkg::IDX_IRQ_CLEAR, 8'h03);
        $display("test wake done");
    endtask : t_wake
    task automatic t_select;
        wr(gpr_pkg::IDX_LDN_SELECT, 8'h01);
        rd(gpr_pkg::IDX_PIN_B1_7 + gpr_pkg::IDX_COMBINED_BASE, v);
        `CHK("moved read", 8'h01, v)
        wr(gpr_pkg::IDX_PIN_B1_7, 8'h80);
        rd(gpr_pkg::IDX_PIN_B1_7, v);
        `CHK("old place", 8'h00, v)
        rd(gpr_pkg::IDX_PIN_B1_7 + gpr_pkg::IDX_COMBINED_BASE, v);
        `CHK("old write ignored", 8'h01, v)
        wr(gpr_pkg::IDX_LDN_SELECT, 8'h00);
        rd(gpr_pkg::IDX_PIN_B1_7 + gpr_pkg::IDX_COMBINED_BASE, v);
        `CHK("moved gone", 8'h00, v)
        $display("test select done");
    endtask : t_select

    // ----------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial
    begin
        #100000;
        errors++;
        summarize();
    end
    initial
    begin
        wt(2);
        rst <= 1'b0;
        t_reset();
        t_reserved();
        t_output();
        t_input_tach();
        t_hold();
        t_data();
        t_display();
        t_down();
        t_wake();
        t_select();
        summarize();
    end
endmodule : tb_gpr_gpio
